//--- src/ptm_pkg.sv
// ----------------------------------------
// periodic timer package
// ----------------------------------------
// constants, codes and carrier structs for the 10-bit periodic timer
// assumes one 100 MHz system clock that also stands in for the high clock
`default_nettype none

package ptm_pkg;

    // ----------------------------------------
    // counter geometry and reset values
    // ----------------------------------------
    localparam int CNT_W = 10;
    localparam logic [9:0] CNT_RST = 10'h000;
    localparam logic [10:0] CNT_WRAP = 11'h400;

    // ----------------------------------------
    // operating mode codes
    // ----------------------------------------
    localparam logic [1:0] MODE_CMP = 2'h0;
    localparam logic [1:0] MODE_UNDEF = 2'h1;
    localparam logic [1:0] MODE_PWM = 2'h2;
    localparam logic [1:0] MODE_TC = 2'h3;

    // ----------------------------------------
    // pin action codes, compare and pwm readings
    // ----------------------------------------
    localparam logic [1:0] IO_NONE = 2'h0;
    localparam logic [1:0] IO_LOW = 2'h1;
    localparam logic [1:0] IO_HIGH = 2'h2;
    localparam logic [1:0] IO_TOGGLE = 2'h3;
    localparam logic [1:0] IO_INACTIVE = 2'h0;
    localparam logic [1:0] IO_ACTIVE = 2'h1;
    localparam logic [1:0] IO_WAVE = 2'h2;
    localparam logic [1:0] IO_PULSE = 2'h3;

    // ----------------------------------------
    // counter clock source codes
    // ----------------------------------------
    localparam logic [2:0] CKS_SYS4 = 3'h0;
    localparam logic [2:0] CKS_SYS = 3'h1;
    localparam logic [2:0] CKS_H16 = 3'h2;
    localparam logic [2:0] CKS_H64 = 3'h3;
    localparam logic [2:0] CKS_SUB0 = 3'h4;
    localparam logic [2:0] CKS_SUB1 = 3'h5;
    localparam logic [2:0] CKS_EXT_RISE = 3'h6;
    localparam logic [2:0] CKS_EXT_FALL = 3'h7;

    // ----------------------------------------
    // clock rates and divider counts
    // ----------------------------------------
    localparam int CLK_RATE_HZ = 100_000_000;
    localparam int SUB_RATE_HZ = 32_768;
    localparam int SUB_DIV_DEF = CLK_RATE_HZ / SUB_RATE_HZ;
    localparam logic [1:0] DIV4_LAST = 2'h3;
    localparam logic [3:0] DIV16_LAST = 4'hf;
    localparam logic [5:0] DIV64_LAST = 6'h3f;

    // ----------------------------------------
    // carrier types
    // ----------------------------------------
    typedef struct packed {
        logic [1:0] mode;
        logic [1:0] io;
        logic oc;
        logic pol;
        logic cclr;
        logic [2:0] clk_sel;
        logic pause;
    } ptm_ctrl_s;

    typedef struct packed {
        logic [9:0] cnt;
        logic run;
        logic lvl;
        logic flag_a;
        logic flag_p;
        logic pin;
        logic oe;
    } ptm_state_s;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic stable;
        logic [1:0] d4;
        logic [5:0] dh;
        logic [11:0] dsub;
        logic tick;
        logic edge_ev;
    } ptm_tick_s;

    localparam ptm_state_s ST_RST = '0;
    localparam ptm_tick_s TICK_RST = '0;

endpackage

`default_nettype wire

//--- src/ptm_tick.sv
// ----------------------------------------
// counter clock enable and pin synchroniser
// ----------------------------------------
// makes the one-cycle count enable from the selected source
// assumes ext_pin is asynchronous to mclk and slower than mclk / 4
`default_nettype none

module ptm_tick #(
    parameter int SUB_DIV = ptm_pkg::SUB_DIV_DEF
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // source select and external pin
    input wire logic [2:0] clk_sel,
    input wire logic ext_pin,
    // enables
    output logic tick,
    output logic ext_edge
);
    import ptm_pkg::*;

    localparam logic [11:0] SUB_LAST = 12'(SUB_DIV - 1);

    generate
        if (SUB_DIV < 2 || SUB_DIV > 4096) begin : g_bad_div
            $error("ptm_tick: SUB_DIV out of range");
        end
    endgenerate

    ptm_tick_s st;
    ptm_tick_s nx;
    logic rise;
    logic fall;
    logic pin_ev;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        nx = st;
        // three stages; only the agreeing last two move the stable level
        nx.s1 = ext_pin;
        nx.s2 = st.s1;
        nx.s3 = st.s2;
        if (st.s2 == st.s3) begin
            nx.stable = st.s3;
        end
        rise = nx.stable & ~st.stable;
        fall = st.stable & ~nx.stable;
        pin_ev = (clk_sel == CKS_EXT_FALL) ? fall : rise;
        nx.d4 = st.d4 + 2'h1;
        nx.dh = st.dh + 6'h01;
        nx.dsub = (st.dsub == SUB_LAST) ? 12'h000 : st.dsub + 12'h001;
        case (clk_sel)
            CKS_SYS4: nx.tick = (st.d4 == DIV4_LAST);
            CKS_SYS: nx.tick = 1'b1;
            CKS_H16: nx.tick = (st.dh[3:0] == DIV16_LAST);
            CKS_H64: nx.tick = (st.dh == DIV64_LAST);
            CKS_SUB0, CKS_SUB1: nx.tick = (st.dsub == SUB_LAST);
            CKS_EXT_RISE, CKS_EXT_FALL: nx.tick = pin_ev;
            default: nx.tick = 1'b0;
        endcase
        nx.edge_ev = pin_ev;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st <= TICK_RST;
        end else begin
            st <= nx;
        end
    end

    assign tick = st.tick;
    assign ext_edge = st.edge_ev;

endmodule

`default_nettype wire

//--- src/ptm_timer.sv
// ----------------------------------------
// 10-bit periodic timer, four modes
// ----------------------------------------
// compare output, timer/counter, edge pwm and single pulse on one counter
// assumes control bits come from logic on MCLK; the pin input is asynchronous
`default_nettype none

module ptm_timer #(
    parameter int SUB_DIV = ptm_pkg::SUB_DIV_DEF
) (
    // clock and reset
    input wire logic MCLK,
    input wire logic RSTN,
    // control bits
    input wire ptm_pkg::ptm_ctrl_s CTRL,
    input wire logic [9:0] COMPARE_A,
    input wire logic [9:0] COMPARE_P,
    // run control pulses
    input wire logic RUN_SET,
    input wire logic RUN_CLR,
    // flag clear pulses
    input wire logic MATCH_A_CLR,
    input wire logic MATCH_P_CLR,
    // external clock or trigger pin
    input wire logic EXTERNAL_CLOCK_PIN,
    // status
    output logic COUNTER_RUN,
    output logic [9:0] COUNT,
    output logic MATCH_A_FLAG,
    output logic MATCH_P_FLAG,
    // timer output pin
    output logic TIMER_OUT,
    output logic TIMER_OE
);
    import ptm_pkg::*;

    ptm_state_s st;
    ptm_state_s nx;
    logic tick;
    logic trig;
    logic is_cmp;
    logic is_pwm;
    logic is_sp;
    logic step;
    logic run_rise;
    logic hit_a;
    logic hit_p;
    logic set_p;
    logic run_on;
    logic run_off;
    logic pwm_on;
    logic base;
    logic [10:0] cnt_inc;
    logic [10:0] period;

    // ----------------------------------------
    // clock enable and pin trigger
    // ----------------------------------------
    ptm_tick #(
        .SUB_DIV(SUB_DIV)
    ) u_tick (
        .mclk(MCLK),
        .rst_n(RSTN),
        .clk_sel(CTRL.clk_sel),
        .ext_pin(EXTERNAL_CLOCK_PIN),
        .tick(tick),
        .ext_edge(trig)
    );

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        nx = st;
        // undefined mode 01 is run as timer/counter, pin left alone
        is_cmp = (CTRL.mode != MODE_PWM);
        is_pwm = (CTRL.mode == MODE_PWM) && (CTRL.io != IO_PULSE);
        is_sp = (CTRL.mode == MODE_PWM) && (CTRL.io == IO_PULSE);
        step = st.run & ~CTRL.pause & tick;
        cnt_inc = {1'b0, st.cnt} + 11'h001;
        period = (COMPARE_P == CNT_RST) ? CNT_WRAP : {1'b0, COMPARE_P};
        hit_p = step & (cnt_inc == period);
        // an all-zero A value never matches, so nothing fires on it
        hit_a = step & (COMPARE_A != CNT_RST) & (cnt_inc == {1'b0, COMPARE_A});

        // run bit: a request only acts on the opposite state
        run_on = RUN_SET | (is_sp & trig);
        run_off = RUN_CLR | (is_sp & hit_a);
        if (st.run) begin
            nx.run = ~run_off;
        end else begin
            nx.run = run_on;
        end
        run_rise = nx.run & ~st.run;

        // counter
        if (run_rise) begin
            nx.cnt = CNT_RST;
        end else if (step) begin
            if (is_sp) begin
                // free wrap; only a restart zeroes it
                nx.cnt = cnt_inc[9:0];
            end else if (is_pwm) begin
                nx.cnt = hit_p ? CNT_RST : cnt_inc[9:0];
            end else if (CTRL.cclr) begin
                nx.cnt = hit_a ? CNT_RST : cnt_inc[9:0];
            end else begin
                nx.cnt = hit_p ? CNT_RST : cnt_inc[9:0];
            end
        end

        // flags: a set in the clear cycle survives
        set_p = hit_p & (is_pwm | (is_cmp & ~CTRL.cclr));
        nx.flag_a = hit_a | (st.flag_a & ~MATCH_A_CLR);
        nx.flag_p = set_p | (st.flag_p & ~MATCH_P_CLR);

        // compare output level
        if (run_rise) begin
            nx.lvl = CTRL.oc;
        end else if (hit_a && is_cmp) begin
            case (CTRL.io)
                IO_LOW: nx.lvl = 1'b0;
                IO_HIGH: nx.lvl = 1'b1;
                IO_TOGGLE: nx.lvl = ~st.lvl;
                default: nx.lvl = st.lvl;
            endcase
        end

        // pin drive; a count at or above A is the inactive part
        pwm_on = nx.run & ({1'b0, nx.cnt} < {1'b0, COMPARE_A});
        case (CTRL.io)
            IO_INACTIVE: base = ~CTRL.oc;
            IO_ACTIVE: base = CTRL.oc;
            IO_WAVE: base = pwm_on ? CTRL.oc : ~CTRL.oc;
            default: base = nx.run ? CTRL.oc : ~CTRL.oc;
        endcase
        if (CTRL.mode == MODE_CMP) begin
            nx.pin = nx.lvl ^ CTRL.pol;
            nx.oe = 1'b1;
        end else if (CTRL.mode == MODE_PWM) begin
            nx.pin = base ^ CTRL.pol;
            nx.oe = 1'b1;
        end else begin
            nx.pin = 1'b0;
            nx.oe = 1'b0;
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            st <= ST_RST;
        end else begin
            st <= nx;
        end
    end

    assign COUNTER_RUN = st.run;
    assign COUNT = st.cnt;
    assign MATCH_A_FLAG = st.flag_a;
    assign MATCH_P_FLAG = st.flag_p;
    assign TIMER_OUT = st.pin;
    assign TIMER_OE = st.oe;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    run_rise_zero_a: assert property (
        @(posedge MCLK) disable iff (!RSTN)
        $rose(st.run) |-> (st.cnt == CNT_RST)
    ) else $error("counter not zero after run rise");

    stop_hold_a: assert property (
        @(posedge MCLK) disable iff (!RSTN)
        !st.run && !nx.run |=> $stable(st.cnt)
    ) else $error("stopped counter moved");

    count_step_a: assert property (
        @(posedge MCLK) disable iff (!RSTN)
        step && is_sp && !run_off |=> st.cnt == $past(st.cnt) + 10'h001
    ) else $error("counter did not step on enable");

    no_p_flag_a: assert property (
        @(posedge MCLK) disable iff (!RSTN)
        is_cmp && CTRL.cclr && !st.flag_p |=> !st.flag_p
    ) else $error("P flag raised with A clear source");

    a_flag_set_a: assert property (
        @(posedge MCLK) disable iff (!RSTN)
        hit_a |=> st.flag_a
    ) else $error("A match lost");

    pwm_period_a: assert property (
        @(posedge MCLK) disable iff (!RSTN)
        is_pwm && hit_p && !run_rise |=> st.cnt == CNT_RST
    ) else $error("pwm period match did not clear");

    pulse_end_a: assert property (
        @(posedge MCLK) disable iff (!RSTN)
        is_sp && hit_a && st.run |=> !st.run && st.flag_a
    ) else $error("pulse not ended by A match");

    pin_trigger_a: assert property (
        @(posedge MCLK) disable iff (!RSTN)
        is_sp && trig && !st.run |=> st.run
    ) else $error("pin edge did not start pulse");

    full_duty_a: assert property (
        @(posedge MCLK) disable iff (!RSTN)
        is_pwm && CTRL.io == IO_WAVE && {1'b0, COMPARE_A} >= period
        && st.run && !RUN_CLR
        |=> TIMER_OUT == ($past(CTRL.oc) ^ $past(CTRL.pol))
    ) else $error("full duty not held");

    init_level_a: assert property (
        @(posedge MCLK) disable iff (!RSTN)
        CTRL.mode == MODE_CMP && run_rise |=> st.lvl == $past(CTRL.oc)
    ) else $error("initial level not loaded");

    no_action_a: assert property (
        @(posedge MCLK) disable iff (!RSTN)
        CTRL.io == IO_NONE && !run_rise |=> $stable(st.lvl)
    ) else $error("pin level changed without action");

    tc_undriven_a: assert property (
        @(posedge MCLK) disable iff (!RSTN)
        CTRL.mode == MODE_TC |=> !TIMER_OE
    ) else $error("pin driven in timer/counter mode");

    cmp_pin_drive_a: assert property (
        @(posedge MCLK) disable iff (!RSTN)
        CTRL.mode == MODE_CMP |=> TIMER_OE && TIMER_OUT == (st.lvl ^ $past(CTRL.pol))
    ) else $error("compare pin not driven from its level");

    p_clear_cmp_a: assert property (
        @(posedge MCLK) disable iff (!RSTN)
        is_cmp && !CTRL.cclr && hit_p |=> st.cnt == CNT_RST
    ) else $error("P match did not clear counter");

    p_flag_set_a: assert property (
        @(posedge MCLK) disable iff (!RSTN)
        is_cmp && !CTRL.cclr && hit_p |=> st.flag_p
    ) else $error("P match lost in compare mode");

    a_clear_cmp_a: assert property (
        @(posedge MCLK) disable iff (!RSTN)
        is_cmp && CTRL.cclr && hit_a |=> st.cnt == CNT_RST
    ) else $error("A match did not clear counter");

    zero_a_wrap_a: assert property (
        @(posedge MCLK) disable iff (!RSTN)
        is_cmp && COMPARE_A == CNT_RST && step && (&st.cnt)
        |=> st.cnt == CNT_RST && !$rose(st.flag_a)
    ) else $error("zero A value did not overflow cleanly");

    pin_on_a_a: assert property (
        @(posedge MCLK) disable iff (!RSTN)
        is_cmp && !hit_a && !run_rise |=> $stable(st.lvl)
    ) else $error("compare level moved without A match");

    pwm_p_flag_a: assert property (
        @(posedge MCLK) disable iff (!RSTN)
        is_pwm && hit_p |=> st.flag_p
    ) else $error("pwm P match lost");

    pwm_forced_a: assert property (
        @(posedge MCLK) disable iff (!RSTN)
        is_pwm && CTRL.io != IO_WAVE && step && !hit_p
        |=> st.cnt == $past(st.cnt) + 10'h001
    ) else $error("pwm counter stalled while pin forced");

    pulse_no_zero_a: assert property (
        @(posedge MCLK) disable iff (!RSTN)
        is_sp && !run_rise && st.cnt != CNT_RST && !(&st.cnt) |=> st.cnt != CNT_RST
    ) else $error("pulse counter zeroed without restart");

    pulse_pin_a: assert property (
        @(posedge MCLK) disable iff (!RSTN)
        is_sp |=> TIMER_OUT == ((st.run ? $past(CTRL.oc) : !$past(CTRL.oc)) ^ $past(CTRL.pol))
    ) else $error("pulse pin does not follow run");

endmodule

`default_nettype wire

//--- verification/ptm_load.sv
// load on the timer pin, and trigger source for the timer's pin input
// assumes the bench holds trig for several mclk periods
`default_nettype none

module ptm_load (
    // clock and bench request
    input wire logic mclk,
    input wire logic trig,
    // timer pin side
    input wire logic pin_out,
    input wire logic pin_oe,
    output logic pad,
    output logic ext_pin
);
    timeunit 1ns;
    timeprecision 1ps;

    // pull-down on the pad: an undriven pin reads low, never the last value
    assign pad = pin_oe ? pin_out : 1'h0;

    // launched just after an edge, held while trig stands
    always @(posedge mclk) begin
        ext_pin <= #1 trig;
    end
endmodule

`default_nettype wire

//--- verification/periodic_timer_modes_tb_top.sv
// bench for the periodic timer: task sequences with worked-out expectations
// assumes ptm_pkg, ptm_timer and ptm_load are compiled first
`default_nettype none

module periodic_timer_modes_tb_top;
    import ptm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk, rstn, run_set, run_clr, clr_a, clr_p, trig;
    ptm_ctrl_s ctrl;
    logic [9:0] cmp_a, cmp_p, cnt, held;
    logic ext_pin, run, flag_a, flag_p, tout, toe, pad;
    int mismatches = 0;
    int compares = 0;
    int cycles = 0;
    int hits, flips;
    // pwm cases: wave, inverted, full duty, forced inactive, forced active
    logic [1:0] pio [5] = '{IO_WAVE, IO_WAVE, IO_WAVE, IO_INACTIVE, IO_ACTIVE};
    logic poc [5] = '{1'h1, 1'h0, 1'h1, 1'h1, 1'h1};
    logic ppol [5] = '{1'h0, 1'h1, 1'h0, 1'h0, 1'h1};
    logic [9:0] pa [5] = '{10'h003, 10'h003, 10'h00a, 10'h003, 10'h003};
    int plv [5] = '{3, 3, 10, 0, 1024};
    // divided sources over 64 cycles, then pin edge sources
    logic [2:0] dsel [5] = '{CKS_SYS4, CKS_H16, CKS_H64, CKS_SUB0, CKS_SUB1};
    logic [9:0] dexp [5] = '{10'h010, 10'h004, 10'h001, 10'h010, 10'h010};
    logic [2:0] esel [2] = '{CKS_EXT_RISE, CKS_EXT_FALL};

    ptm_timer #(.SUB_DIV(4)) i_dut (.MCLK(mclk), .RSTN(rstn), .CTRL(ctrl), .COMPARE_A(cmp_a),
        .COMPARE_P(cmp_p), .RUN_SET(run_set), .RUN_CLR(run_clr), .MATCH_A_CLR(clr_a),
        .MATCH_P_CLR(clr_p), .EXTERNAL_CLOCK_PIN(ext_pin), .COUNTER_RUN(run), .COUNT(cnt),
        .MATCH_A_FLAG(flag_a), .MATCH_P_FLAG(flag_p), .TIMER_OUT(tout), .TIMER_OE(toe));
    ptm_load i_load (.mclk(mclk), .trig(trig), .pin_out(tout), .pin_oe(toe), .pad(pad),
        .ext_pin(ext_pin));

    initial begin
        mclk = 1'h0;
        forever #5 mclk = ~mclk;
    end

    // ----------------------------------------
    // checks and drivers
    // ----------------------------------------
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // whole run is about 2800 cycles
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            end_of_test();
        end
    end

    task automatic check_bit(input string what, input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic check_cnt(input string what, input logic [9:0] exp, input logic [9:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic pulse(ref logic sig);
        @(negedge mclk) sig = 1'h1;
        @(negedge mclk) sig = 1'h0;
    endtask

    // stop first: mode and pin action only change while stopped
    task automatic setup(input logic [1:0] m, i, input logic oc, pol, cc,
                         input logic [9:0] a, p, input logic [2:0] cks);
        pulse(run_clr);
        clr_a = 1'h1;
        clr_p = 1'h1;
        ctrl = '{mode: m, io: i, oc: oc, pol: pol, cclr: cc, clk_sel: cks, pause: 1'h0};
        cmp_a = a;
        cmp_p = p;
        @(negedge mclk);
        clr_a = 1'h0;
        clr_p = 1'h0;
    endtask

    // follows the count from the first cycle after a start
    task automatic run_chk(input int top, a_hit, a_lvl, n, input logic lvl, act);
        int e;
        logic prev;
        e = 0;
        hits = 0;
        flips = 0;
        prev = pad;
        repeat (n) begin
            check_cnt("count", e[9:0], cnt);
            if (lvl)
                check_bit("pwm pin", (e < a_lvl) ? act : ~act, pad);
            if (e + 1 == a_hit)
                hits++;
            e = (e + 1 == top) ? 0 : e + 1;
            @(negedge mclk);
            if (pad !== prev)
                flips++;
            prev = pad;
        end
        check_bit("flag a", hits != 0, flag_a);
    endtask

    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        {rstn, run_set, run_clr, clr_a, clr_p, trig} = '0;
        ctrl = '0;
        cmp_a = '0;
        cmp_p = '0;
        repeat (10) @(negedge mclk);
        check_cnt("reset count", 10'h000, cnt);
        check_bit("reset run", 1'h0, run);
        rstn = 1'h1;
        @(negedge mclk);
        check_bit("reset oe", 1'h1, toe);
        setup(MODE_CMP, IO_TOGGLE, 1'h0, 1'h0, 1'h1, 10'h005, 10'h002, CKS_SYS);
        pulse(run_set);
        run_chk(5, 5, 0, 18, 1'h0, 1'h0);
        check_bit("flag p", 1'h0, flag_p);
        check_cnt("toggles", hits[9:0], flips[9:0]);
        pulse(run_clr);
        held = cnt;
        repeat (3) @(negedge mclk);
        check_cnt("held", held, cnt);
        pulse(run_set);
        check_bit("initial", 1'h0, pad);
        check_cnt("restart", 10'h000, cnt);
        setup(MODE_CMP, IO_HIGH, 1'h0, 1'h0, 1'h0, 10'h003, 10'h006, CKS_SYS);
        pulse(run_set);
        run_chk(6, 3, 0, 14, 1'h0, 1'h0);
        check_bit("flag p", 1'h1, flag_p);
        check_bit("pin high", 1'h1, pad);
        pulse(run_clr);
        pulse(run_set);
        check_bit("restart level", 1'h0, pad);
        setup(MODE_CMP, IO_LOW, 1'h1, 1'h0, 1'h0, 10'h000, 10'h000, CKS_SYS);
        pulse(run_set);
        run_chk(1024, 0, 0, 1030, 1'h0, 1'h0);
        check_bit("flag p", 1'h1, flag_p);
        check_bit("pin kept", 1'h1, pad);
        setup(MODE_CMP, IO_NONE, 1'h1, 1'h0, 1'h1, 10'h004, 10'h000, CKS_SYS);
        pulse(run_set);
        run_chk(4, 4, 0, 10, 1'h0, 1'h0);
        check_cnt("flips", 10'h000, flips[9:0]);
        setup(MODE_TC, IO_TOGGLE, 1'h0, 1'h0, 1'h1, 10'h005, 10'h002, CKS_SYS);
        pulse(run_set);
        run_chk(5, 5, 0, 12, 1'h0, 1'h0);
        check_bit("flag p", 1'h0, flag_p);
        check_bit("oe", 1'h0, toe);
        for (int k = 0; k < 5; k++) begin
            setup(MODE_PWM, pio[k], poc[k], ppol[k], 1'h1, pa[k], 10'h008, CKS_SYS);
            pulse(run_set);
            run_chk(8, pa[k], plv[k], 20, 1'h1, poc[k] ^ ppol[k]);
            check_bit("flag p", 1'h1, flag_p);
        end
        setup(MODE_PWM, IO_WAVE, 1'h1, 1'h0, 1'h0, 10'h3e8, 10'h000, CKS_SYS);
        pulse(run_set);
        run_chk(1024, 1000, 1000, 1030, 1'h1, 1'h1);
        setup(MODE_PWM, IO_PULSE, 1'h1, 1'h0, 1'h1, 10'h005, 10'h002, CKS_SYS);
        pulse(run_set);
        run_chk(1024, 5, 5, 5, 1'h1, 1'h1);
        check_bit("auto stop", 1'h0, run);
        check_bit("trailing", 1'h0, pad);
        trig = 1'h1;
        for (int w = 0; w < 20 && run !== 1'h1; w++)
            @(negedge mclk);
        check_bit("trigger run", 1'h1, run);
        check_cnt("trigger count", 10'h000, cnt);
        check_bit("trigger pin", 1'h1, pad);
        trig = 1'h0;
        repeat (8) @(negedge mclk);
        check_bit("trigger stop", 1'h0, run);
        setup(MODE_PWM, IO_PULSE, 1'h0, 1'h0, 1'h0, 10'h000, 10'h000, CKS_SYS);
        pulse(run_set);
        check_bit("leading", 1'h0, pad);
        repeat (3) @(negedge mclk);
        pulse(run_clr);
        check_bit("clr trailing", 1'h1, pad);
        for (int k = 0; k < 5; k++) begin
            setup(MODE_CMP, IO_NONE, 1'h0, 1'h0, 1'h1, 10'h000, 10'h000, dsel[k]);
            pulse(run_set);
            repeat (64) @(negedge mclk);
            check_cnt("divided", dexp[k], cnt);
        end
        ctrl.pause = 1'h1;
        @(negedge mclk);
        held = cnt;
        repeat (12) @(negedge mclk);
        check_cnt("paused", held, cnt);
        for (int s = 0; s < 2; s++) begin
            setup(MODE_CMP, IO_NONE, 1'h0, 1'h0, 1'h1, 10'h000, 10'h000, esel[s]);
            pulse(run_set);
            repeat (3) begin
                trig = 1'h1;
                repeat (8) @(negedge mclk);
                trig = 1'h0;
                repeat (8) @(negedge mclk);
            end
            check_cnt("pin clock", 10'h003, cnt);
        end
        end_of_test();
    end
endmodule

`default_nettype wire
